// ==== bench/sbs_jtag_ctl.sv ====
`timescale 1ns/1ps
module sbs_jtag_ctl (
    input  wire logic clk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    logic o;
    // Test clock stands low between frames; pulled-up lines idle high
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 160 ns test-clock period; entered just after a system clock edge
    task automatic step(input logic m, input logic d, output logic q);
        #1 tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(posedge clk);
        #1 tck = 1'b1;
        repeat (4) @(posedge clk);
        q = tdo; // Launched at the fall, long settled here
    endtask
    task automatic walk(input int k, input logic m);
        @(posedge clk);
        repeat (k) step(m, 1'b1, o);
        #1 tck = 1'b0;
    endtask
    task automatic scan(input logic ir, input int n, input logic [39:0] din, output logic [39:0] dout);
        dout = '0;
        @(posedge clk);
        step(1'b1, 1'b1, o);
        if (ir)
            step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        #1 tck = 1'b0;
    endtask
endmodule // sbs_jtag_ctl

// ==== bench/sbs_tap_properties.sv ====
`timescale 1ns/1ps
module sbs_tap_properties (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       tck,
    input wire logic       tms,
    input wire logic       tdi,
    input wire logic [7:0] ioRing,
    input wire logic       tdo,
    input wire logic       tdoOe,
    input wire logic       memOutFloat,
    input wire logic [3:0] tapState
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic       tck_q;
    logic [2:0] highRises_q;
    // Counts test-clock rises with mode select high; saturates so the reset is seen once
    always_ff @(posedge clk)
    begin
        tck_q <= tck;
        if (srst)
            highRises_q <= 3'h0;
        else if (tck && !tck_q)
            highRises_q <= !tms ? 3'h0 : (highRises_q == 3'h5 ? 3'h5 : highRises_q + 3'h1);
    end
    sequence shiftEntry;
        $rose(tdoOe);
    endsequence
    reset_state_a:
        assert property (disable iff (1'b0) srst |=> tapState == 4'h0 && !tdoOe) else $error("reset state wrong");
    tms_reset_a:
        assert property ($rose(highRises_q == 3'h5) |-> ##[1:6] tapState == 4'h0) else $error("no tms reset");
    state_rise_a:
        assert property ($changed(tapState) |-> $past(tck, 2)) else $error("state moved off rise");
    tdo_launch_a:
        assert property ($changed(tdo) || $changed(tdoOe) |-> !$past(tck, 2)) else $error("tdo moved off fall");
    oe_shift_a:
        assert property (shiftEntry |-> tapState == 4'h4 || tapState == 4'hB) else $error("tdo driven outside shift");
    capir_pattern_a:
        assert property (shiftEntry ##0 tapState == 4'hB |-> tdo) else $error("ir capture lsb wrong");
    idle_quiet_a:
        assert property (tapState == 4'h0 || tapState == 4'h1 |-> !tdoOe) else $error("tdo driven when idle");
    float_update_a:
        assert property ($changed(memOutFloat) |-> tapState inside {4'h0, 4'hF} || $past(tapState) inside {4'h0, 4'hF})
            else $error("float changed outside update");
endmodule // sbs_tap_properties
bind sbs_tap sbs_tap_properties u_sbs_tap_properties (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .ioRing(ioRing), .tdo(tdo), .tdoOe(tdoOe), .memOutFloat(memOutFloat), .tapState(tapState));

// ==== bench/sbs_tap_test.sv ====
`timescale 1ns/1ps
module sbs_tap_test;
    localparam logic [31:0] ID_VAL = 32'h0000A5C3; // Arbitrary identification value
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  ioRing = 8'h00;
    logic        tck, tms, tdi, tdo, tdoOe, memOutFloat;
    logic [3:0]  tapState;
    logic [39:0] rd;
    wire         tdoPin = tdoOe ? tdo : 1'bz;
    int          errors = 0;
    int          checkCount = 0;
    always #10 clk = ~clk;
    sbs_tap #(.ID_CODE(ID_VAL)) u_sbs_tap (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
        .ioRing(ioRing), .tdo(tdo), .tdoOe(tdoOe), .memOutFloat(memOutFloat), .tapState(tapState));
    sbs_jtag_ctl u_sbs_jtag_ctl (.clk(clk), .tdo(tdoPin), .tck(tck), .tms(tms), .tdi(tdi));
    task automatic check(input logic [39:0] seen, input logic [39:0] want, input string msg);
        checkCount++;
        if (seen !== want)
        begin
            errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, want);
        end
    endtask
    task automatic test_done;
        if (errors == 0 && checkCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic loadIr(input logic [2:0] op);
        u_sbs_jtag_ctl.scan(1'b1, 3, {37'h0, op}, rd);
        check(rd[1:0], 2'h1, "ir capture");
    endtask
    task automatic testPowerUp;
        check({tapState, tdoOe, memOutFloat}, 6'h00, "after reset");
    endtask
    task automatic testIdcode;
        u_sbs_jtag_ctl.walk(1, 1'b0);
        u_sbs_jtag_ctl.scan(1'b0, 40, 40'hA5, rd);
        check(rd[31:0], ID_VAL, "id code");
        check(rd[39:32], 8'hA5, "id pass through");
    endtask
    task automatic testBypass;
        logic [2:0] ops [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        foreach (ops[i])
        begin
            loadIr(ops[i]);
            u_sbs_jtag_ctl.scan(1'b0, 8, 40'hC3, rd);
            check(rd[7:0], 8'h86, "bypass path");
        end
    endtask
    task automatic testSample;
        logic [2:0] ops [3] = '{3'h0, 3'h2, 3'h4};
        foreach (ops[i])
        begin
            @(posedge clk) #1 ioRing = 8'h96 ^ 8'(i);
            loadIr(ops[i]);
            check(memOutFloat, ops[i] != 3'h4, "output float");
            u_sbs_jtag_ctl.scan(1'b0, 8, 40'h0, rd);
            check(rd[7:0], ioRing, "ring capture");
        end
    endtask
    task automatic testTmsReset;
        loadIr(3'h2);
        u_sbs_jtag_ctl.walk(5, 1'b1);
        repeat (4) @(posedge clk);
        check({tapState, memOutFloat}, 5'h00, "tms reset");
        u_sbs_jtag_ctl.walk(1, 1'b0);
        u_sbs_jtag_ctl.scan(1'b0, 32, 40'h0, rd);
        check(rd[31:0], ID_VAL, "id after reset");
    endtask
    // Whole run needs well under 100 us of test-clock traffic
    initial
    begin
        #200000;
        errors++;
        test_done();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        repeat (5) @(posedge clk);
        testPowerUp();
        testIdcode();
        testBypass();
        testSample();
        testTmsReset();
        test_done();
    end
endmodule // sbs_tap_test

// ==== verilog/sbs_tap.v ====
`timescale 1ns/1ps
`include "sbs_tap_map.vh"

module sbs_tap #(
    parameter [2:0] OP_IDCODE  = `SBS_OP_IDCODE,
    parameter [2:0] OP_SAMPLEZ = `SBS_OP_SAMPLEZ,
    parameter [2:0] OP_SAMPLE  = `SBS_OP_SAMPLE,
    parameter [2:0] OP_BYPASS  = `SBS_OP_BYPASS,
    parameter [31:0] ID_CODE   = `SBS_ID_CODE
) (
    input  wire                    clk,
    input  wire                    srst,
    input  wire                    tck,
    input  wire                    tms,
    input  wire                    tdi,
    input  wire [`SBS_BSR_W-1:0]   ioRing,
    output reg                     tdo,
    output reg                     tdoOe,
    output reg                     memOutFloat,
    output reg  [3:0]              tapState
);

    // ==========================================
    // Controller states, one-hot
    // The bit position of each state is the index shown on tapState
    localparam [15:0] S_RESET = 16'h0001;
    localparam [15:0] S_IDLE  = 16'h0002;
    localparam [15:0] S_SELDR = 16'h0004;
    localparam [15:0] S_CAPDR = 16'h0008;
    localparam [15:0] S_SHDR  = 16'h0010;
    localparam [15:0] S_EX1DR = 16'h0020;
    localparam [15:0] S_PSDR  = 16'h0040;
    localparam [15:0] S_EX2DR = 16'h0080;
    localparam [15:0] S_UPDR  = 16'h0100;
    localparam [15:0] S_SELIR = 16'h0200;
    localparam [15:0] S_CAPIR = 16'h0400;
    localparam [15:0] S_SHIR  = 16'h0800;
    localparam [15:0] S_EX1IR = 16'h1000;
    localparam [15:0] S_PSIR  = 16'h2000;
    localparam [15:0] S_EX2IR = 16'h4000;
    localparam [15:0] S_UPIR  = 16'h8000;

    // ==========================================
    // Synchronisers: pins pass two flops before use
    reg [1:0] tckSync_q;
    reg [1:0] tmsSync_q;
    reg [1:0] tdiSync_q;
    reg       tckPrev_q;
    wire      tckRise = tckSync_q[1] & ~tckPrev_q;
    wire      tckFall = ~tckSync_q[1] & tckPrev_q;

    always @(posedge clk)
    begin
        if (srst)
        begin
            tckSync_q <= 2'h0;
            tmsSync_q <= 2'h3;                        // Pull-up: idle high
            tdiSync_q <= 2'h3;
            tckPrev_q <= 1'b0;
        end
        else
        begin
            tckSync_q <= {tckSync_q[0], tck};
            tmsSync_q <= {tmsSync_q[0], tms};
            tdiSync_q <= {tdiSync_q[0], tdi};
            tckPrev_q <= tckSync_q[1];
        end
    end

    wire tmsS = tmsSync_q[1];
    wire tdiS = tdiSync_q[1];

    // ==========================================
    // State machine
    reg [15:0] state_q;
    reg [15:0] state_d;

    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_RESET: state_d = tmsS ? S_RESET : S_IDLE;
            S_IDLE:  state_d = tmsS ? S_SELDR : S_IDLE;
            S_SELDR: state_d = tmsS ? S_SELIR : S_CAPDR;
            S_CAPDR: state_d = tmsS ? S_EX1DR : S_SHDR;
            S_SHDR:  state_d = tmsS ? S_EX1DR : S_SHDR;
            S_EX1DR: state_d = tmsS ? S_UPDR  : S_PSDR;
            S_PSDR:  state_d = tmsS ? S_EX2DR : S_PSDR;
            S_EX2DR: state_d = tmsS ? S_UPDR  : S_SHDR;
            S_UPDR:  state_d = tmsS ? S_SELDR : S_IDLE;
            S_SELIR: state_d = tmsS ? S_RESET : S_CAPIR;
            S_CAPIR: state_d = tmsS ? S_EX1IR : S_SHIR;
            S_SHIR:  state_d = tmsS ? S_EX1IR : S_SHIR;
            S_EX1IR: state_d = tmsS ? S_UPIR  : S_PSIR;
            S_PSIR:  state_d = tmsS ? S_EX2IR : S_PSIR;
            S_EX2IR: state_d = tmsS ? S_UPIR  : S_SHIR;
            S_UPIR:  state_d = tmsS ? S_SELDR : S_IDLE;
            default: state_d = S_RESET;
        endcase
    end

    // ==========================================
    // Decoding of the active instruction
    reg  [`SBS_IR_W-1:0] irShift_q;
    reg  [`SBS_IR_W-1:0] irActive_q;
    reg                  bypass_q;
    reg  [`SBS_ID_W-1:0] idShift_q;
    reg  [`SBS_BSR_W-1:0] bsr_q;

    // Scan register selectors
    localparam [1:0] SEL_BYP = 2'h0;
    localparam [1:0] SEL_ID  = 2'h1;
    localparam [1:0] SEL_BSR = 2'h2;

    // Reserved codes fall through to bypass so the chain never opens
    function [1:0] selectReg;
        input [2:0] op;
        begin
            if (op == `SBS_OP_EXTEST || op == OP_SAMPLEZ || op == OP_SAMPLE)
                selectReg = SEL_BSR;
            else if (op == OP_IDCODE)
                selectReg = SEL_ID;
            else
                selectReg = SEL_BYP;
        end
    endfunction

    wire [1:0] drSel = selectReg(irActive_q);

    // ==========================================
    // Controller, moved on test-clock rise
    always @(posedge clk)
    begin
        if (srst)
            state_q <= S_RESET;
        else if (tckRise)
            state_q <= state_d;
    end

    // ==========================================
    // Instruction register: shift stage and active copy
    // Only Update-IR copies the stage, so a half-shifted code never reroutes the chain
    always @(posedge clk)
    begin
        if (srst)
        begin
            irShift_q  <= OP_IDCODE;
            irActive_q <= OP_IDCODE;
        end
        else if (tckRise)
        begin
            case (state_q)
                S_RESET:
                begin
                    irShift_q  <= OP_IDCODE;
                    irActive_q <= OP_IDCODE;
                end
                S_CAPIR:
                    irShift_q <= {irShift_q[2], `SBS_IR_CAPTURE};
                S_SHIR:
                    irShift_q <= {tdiS, irShift_q[2:1]};
                S_UPIR:
                    irActive_q <= irShift_q;
                default:
                begin
                end
            endcase
        end
    end

    // ==========================================
    // Bypass stage
    // Captures low so a bypassed device reads as one zero ahead of the shifted data
    always @(posedge clk)
    begin
        if (srst)
            bypass_q <= 1'b0;
        else if (tckRise && drSel == SEL_BYP)
        begin
            if (state_q == S_CAPDR)
                bypass_q <= 1'b0;
            else if (state_q == S_SHDR)
                bypass_q <= tdiS;
        end
    end

    // ==========================================
    // Identification stage
    // Reloaded on every capture, so a cut-short shift never leaves a stale code
    always @(posedge clk)
    begin
        if (srst)
            idShift_q <= {`SBS_ID_W{1'b0}};
        else if (tckRise && drSel == SEL_ID)
        begin
            if (state_q == S_CAPDR)
                idShift_q <= ID_CODE;
            else if (state_q == S_SHDR)
                idShift_q <= {tdiS, idShift_q[`SBS_ID_W-1:1]};
        end
    end

    // ==========================================
    // Boundary stage over the I/O ring
    // Ring values are taken at one system clock edge; a ring bit moving then may land either way
    always @(posedge clk)
    begin
        if (srst)
            bsr_q <= {`SBS_BSR_W{1'b0}};
        else if (tckRise && drSel == SEL_BSR)
        begin
            if (state_q == S_CAPDR)
                bsr_q <= ioRing;
            else if (state_q == S_SHDR)
                bsr_q <= {tdiS, bsr_q[`SBS_BSR_W-1:1]};
        end
    end

    // ==========================================
    // Output stage launched on test-clock fall
    reg tdoBit;

    always @*
    begin
        // In Shift-IR the instruction stage sits in the chain, whatever the selector says
        if (state_q == S_SHIR)
            tdoBit = irShift_q[0];
        else if (drSel == SEL_BYP)
            tdoBit = bypass_q;
        else if (drSel == SEL_ID)
            tdoBit = idShift_q[0];
        else
            tdoBit = bsr_q[0];
    end

    function [3:0] stateCode;
        input [15:0] s;
        integer i;
        begin
            stateCode = 4'h0;
            for (i = 0; i < 16; i = i + 1)
                if (s[i])
                    stateCode = i[3:0];
        end
    endfunction

    // ==========================================
    // Test data out, launched on test-clock fall
    // Enable follows the state seen at the fall, so it drops one fall after a shift state is left
    always @(posedge clk)
    begin
        if (srst)
        begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end
        else if (tckFall)
        begin
            tdoOe <= (state_q == S_SHIR) || (state_q == S_SHDR);
            tdo   <= tdoBit;
        end
    end

    // ==========================================
    // Status towards the memory core
    // Floating follows the active code only, never the half-shifted stage
    always @(posedge clk)
    begin
        if (srst)
        begin
            memOutFloat <= 1'b0;
            tapState    <= 4'h0;
        end
        else
        begin
            tapState    <= stateCode(state_q);
            memOutFloat <= (irActive_q == `SBS_OP_EXTEST) ||
                           (irActive_q == OP_SAMPLEZ);
        end
    end

endmodule // sbs_tap

// ==== verilog/sbs_tap_map.vh ====
`ifndef SBS_TAP_MAP_VH
`define SBS_TAP_MAP_VH
// ==========================================
// Register widths
`define SBS_IR_W        3
`define SBS_ID_W        32
`define SBS_BSR_W       8
// ==========================================
// Instruction codes
`define SBS_OP_EXTEST   3'h0
`define SBS_OP_IDCODE   3'h1
`define SBS_OP_SAMPLEZ  3'h2
`define SBS_OP_SAMPLE   3'h4
`define SBS_OP_BYPASS   3'h7
// Fixed pattern captured into the low instruction bits
`define SBS_IR_CAPTURE  2'h1
// ==========================================
// Identification code (arbitrary neutral value)
`define SBS_ID_CODE     32'h00000001
// ==========================================
// Timing
`define SBS_CLK_NS      20
`define SBS_RESET_TMS_EDGES 5
`endif
